/* File: tb_tpwm_unit.sv */
// Self-checking bench for the PWM timer unit over its register port.
// Assumes the load model on the pins and a 100 MHz clock.
module tb_tpwm_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic sleep_in = 1'b0;
   logic adc_busy_in = 1'b0;
   logic clks_four_in = 1'b0;
   logic [15:0] rdata_out;
   logic [2:0] pin_out;
   logic irq_out;
   int hi [3];
   int per [3];
   int rises [3];
   int fail_count = 0;
   int checks = 0;
   logic [15:0] a;
   logic [15:0] b;

   // ********************
   // Clock, design, load
   // ********************
   initial
   begin
      forever #5 clk_in = ~clk_in;
   end

   tpwm_unit #(.WIDTH(10)) u_tpwm_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .sleep_in(sleep_in), .adc_busy_in(adc_busy_in), .clks_four_in(clks_four_in),
      .rdata_out(rdata_out), .channel_output_pin_out(pin_out), .irq_out(irq_out));
   tpwm_load_model u_tpwm_load_model (.clk_in(clk_in), .pin_in(pin_out),
      .hi_len_out(hi), .per_len_out(per), .rises_out(rises));

   // Bus cycles: strobes last one cycle, read data sampled the cycle after
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      @(posedge clk_in);
      addr_in <= ad;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [15:0] d);
      @(posedge clk_in);
      addr_in <= ad;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] ad, input logic [15:0] exp);
      rd(ad, a);
      chk(a, exp);
   endtask
   task automatic chk_len(input int ch, input int h, input int p);
      checks++;
      if (hi[ch] != h || per[ch] != p)
      begin
         fail_count++;
         $display("ERROR %0t: ch%0d high %0d period %0d", $time, ch, hi[ch], per[ch]);
      end
   endtask
   // Bounded wait; a dead pin shows up as a length mismatch
   task automatic wait_rises(input int ch, input int n);
      int s;
      s = rises[ch];
      for (int i = 0; i < 20000 && rises[ch] < s + n; i++)
         @(negedge clk_in);
   endtask
   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog well past the expected run of some 13000 cycles
   initial
   begin
      #1000000;
      fail_count++;
      end_sim();
   end

   // ********************
   // Tests
   // ********************
   initial
   begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      chk_reg(8'h05, 16'h0000);
      chk_reg(8'h06, 16'h0000);
      chk_reg(8'h18, 16'h0001);
      wr(8'h18, 16'h03FF);
      chk_reg(8'h18, 16'h0001);
      wr(8'h30, 16'hFFFF);
      chk_reg(8'h30, 16'h0000);
      $display("test registers done");
      wr(8'h10, 16'h0008);
      wr(8'h14, 16'h0003);
      for (int ps = 0; ps < 8; ps++)
      begin
         wr(8'h05, 16'h0028 | 16'(ps));
         wait_rises(0, 3);
         chk_len(0, 3 * (2 << ps), 8 * (2 << ps));
      end
      $display("test prescale done");
      wr(8'h11, 16'h0005);
      wr(8'h15, 16'h0002);
      wr(8'h12, 16'h0004);
      wr(8'h16, 16'h0001);
      wr(8'h05, 16'h00E8);
      wr(8'h06, 16'h009A);
      wait_rises(1, 3);
      wait_rises(2, 3);
      chk_len(1, 8, 20);
      chk_len(2, 8, 32);
      clks_four_in <= 1'b1;
      wait_rises(0, 3);
      chk_len(0, 12, 32);
      clks_four_in <= 1'b0;
      $display("test channels done");
      wr(8'h05, 16'h00E9);
      wait_rises(0, 2);
      wr(8'h14, 16'h0006);
      wait_rises(0, 1);
      chk_len(0, 12, 32);
      wait_rises(0, 1);
      chk_len(0, 24, 32);
      $display("test duty done");
      chk_reg(8'h20, 16'h0007);
      chk({15'h0000, irq_out}, 16'h0000);
      wr(8'h21, 16'h0001);
      repeat (2) @(posedge clk_in);
      #1 chk({15'h0000, irq_out}, 16'h0001);
      wr(8'h05, 16'h0000);
      wr(8'h06, 16'h0000);
      wr(8'h20, 16'h0007);
      rd(8'h18, b);
      repeat (6) @(posedge clk_in);
      chk_reg(8'h18, b);
      chk_reg(8'h20, 16'h0000);
      chk({15'h0000, irq_out}, 16'h0000);
      $display("test interrupt done");
      wr(8'h05, 16'h0008);
      sleep_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rd(8'h18, b);
      repeat (6) @(posedge clk_in);
      chk_reg(8'h18, b);
      sleep_in <= 1'b0;
      adc_busy_in <= 1'b1;
      @(posedge clk_in);
      sleep_in <= 1'b1;
      rd(8'h18, a);
      repeat (6) @(posedge clk_in);
      rd(8'h18, b);
      chk(16'(a !== b), 16'h0001);
      adc_busy_in <= 1'b0;
      rd(8'h18, a);
      repeat (6) @(posedge clk_in);
      rd(8'h18, b);
      chk(16'(a !== b), 16'h0001);
      sleep_in <= 1'b0;
      wr(8'h21, 16'h0000);
      $display("test sleep done");
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      chk_reg(8'h05, 16'h0000);
      chk_reg(8'h06, 16'h0000);
      $display("test second reset done");
      end_sim();
   end
endmodule

/* File: tpwm_channel.sv */
// One timer/PWM channel: prescaler, 10-bit counter, duty latch and compare.
// Assumes a single clock; tick_in is the instruction-cycle strobe of the core.
`include "tpwm_defs.svh"
module tpwm_channel
   import tpwm_pkg::*;
#(
   parameter int WIDTH = 10
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic tick_in,
   input wire logic run_in,
   input wire logic out_en_in,
   input wire tpwm_ps_t prescale_in,
   input wire logic [WIDTH-1:0] period_in,
   input wire logic [WIDTH-1:0] duty_in,
   output logic [WIDTH-1:0] count_out,
   output logic pin_out,
   output logic match_out
);
   initial
   begin
      if (WIDTH < 2 || WIDTH > 16)
      begin
         $error("tpwm_channel: WIDTH out of range");
      end
   end

   logic [7:0] pre_q;
   logic [7:0] pre_top;
   logic inc;
   logic at_period;
   logic [WIDTH-1:0] duty_latch_q;

   // ***********************************************
   // Prescaler
   // ***********************************************
   // Ratio 2^(sel+1): 000 gives 1:2, 111 gives 1:256
   assign pre_top = 8'((9'h002 << prescale_in) - 9'h001);
   assign inc = run_in && tick_in && (pre_q == pre_top);

   // Prescale count, cleared on reset and while stopped
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !run_in)
         pre_q <= 8'h00;
      else if (tick_in)
         pre_q <= (pre_q == pre_top) ? 8'h00 : 8'(pre_q + 8'h01);
   end

   // ***********************************************
   // Counter, period compare and duty latch
   // ***********************************************
   // Equality seen during the current increment interval; acted on at the next increment,
   // so the counter climbs past the period setpoint only if it already stands above it, as with the reset setpoint of 0
   assign at_period = (count_out == period_in);

   // Counter runs to period, then on next increment clears to reload value
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         count_out <= WIDTH'(`TPWM_COUNT_RELOAD);
      else if (inc)
      begin
         if (at_period)
            count_out <= WIDTH'(`TPWM_COUNT_RELOAD);
         else
            count_out <= WIDTH'(count_out + 1'b1);
      end
   end

   // Duty copied only on the clearing increment; writes before then stay pending
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         duty_latch_q <= '0;
      else if (inc && at_period)
         duty_latch_q <= duty_in;
   end

   // Pin high at period start, low on duty match; high time = duty * tick period * ratio
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !out_en_in)
         pin_out <= 1'b0;
      else if (inc && at_period)
         pin_out <= 1'b1;
      else if (inc && (count_out == duty_latch_q))
         pin_out <= 1'b0;
   end

   // Match pulse in the same cycle the output is set by the period match
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         match_out <= 1'b0;
      else
         match_out <= inc && at_period;
   end
endmodule

/* File: tpwm_defs.svh */
// Register offsets, field positions, reset values and timing counts of the PWM timer unit.
// Assumes inclusion by bare name from the design files.
`ifndef TPWM_DEFS_SVH
`define TPWM_DEFS_SVH

// ***********************************************
// Register offsets (byte addresses on the plain port)
// ***********************************************
`define TPWM_OFF_CTRL1 8'h05
`define TPWM_OFF_CTRL23 8'h06
`define TPWM_OFF_PERIOD1 8'h10
`define TPWM_OFF_DUTY1 8'h14
`define TPWM_OFF_COUNT1 8'h18
`define TPWM_OFF_STATUS 8'h20
`define TPWM_OFF_MASK 8'h21
`define TPWM_CH_STRIDE 8'h01

// ***********************************************
// Field positions
// ***********************************************
`define TPWM_C1_OUTEN_LSB 5
`define TPWM_C1_EN_BIT 3
`define TPWM_C2_EN_BIT 7
`define TPWM_C2_PS_LSB 4
`define TPWM_C3_EN_BIT 3
`define TPWM_C3_PS_LSB 0

// ***********************************************
// Reset values and counts
// ***********************************************
`define TPWM_CTRL_RST 8'h00
`define TPWM_COUNT_RELOAD 10'h001
`define TPWM_CLKS_FOUR 1'b1
`endif

/* File: tpwm_load_model.sv */
// Load on the three PWM pins: measures high time, period and pulse count.
// Assumes the pins are sampled on clk_in; lengths are in clock cycles.
module tpwm_load_model
(
   input wire logic clk_in,
   input wire logic [2:0] pin_in,
   output int hi_len_out [3],
   output int per_len_out [3],
   output int rises_out [3]
);
   timeunit 1ns;
   timeprecision 1ps;
   int hi_q [3];
   int per_q [3];
   logic [2:0] last_q = 3'h0;

   // Count cycles high and between rising edges; the last full figure is kept
   always @(posedge clk_in)
   begin
      last_q <= pin_in;
      for (int i = 0; i < 3; i++)
      begin
         hi_q[i] <= pin_in[i] ? hi_q[i] + 1 : 0;
         per_q[i] <= (pin_in[i] && !last_q[i]) ? 1 : per_q[i] + 1;
         if (pin_in[i] && !last_q[i])
         begin
            per_len_out[i] <= per_q[i];
            rises_out[i] <= rises_out[i] + 1;
         end
         if (!pin_in[i] && last_q[i])
            hi_len_out[i] <= hi_q[i];
      end
   end
endmodule

/* File: tpwm_pkg.sv */
// Types shared by the PWM timer unit.
// Assumes tpwm_defs.svh is compiled alongside.
package tpwm_pkg;
   typedef logic [9:0] tpwm_word_t;
   typedef logic [2:0] tpwm_ps_t;
endpackage

/* File: tpwm_unit.sv */
// Overview of operation
// - duty setpoint copies into duty latch only when counter is cleared.
// - output pin goes low when duty latch equals counter.
// - duty writes any time; held pending until period end transfers them.
// - high time equals duty times oscillator period times CLKS times prescale.
// - period match flag sets in the cycle the output goes high.
// - three 10-bit prescaled counters, read-only to software.
// - sleep stops counters unless an analog conversion is running when sleep starts.
// - prescaler ratios 1:2 through 1:256 from a three-bit field.
// - any reset clears every prescaler selection.
// - counter increments to period then reloads with 1.
// - increment after period match clears counter, sets pin, latches duty.
// - clearing a counter enable stops that counter.
//
// Top of the three-channel PWM timer unit with its register port.
// Assumes a one-cycle read latency master and synchronous inputs on clk_in.
//
// Chosen here: the strobed register port.
`include "tpwm_defs.svh"
module tpwm_unit
   import tpwm_pkg::*;
#(
   parameter int WIDTH = 10
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic sleep_in,
   input wire logic adc_busy_in,
   input wire logic clks_four_in,
   output logic [15:0] rdata_out,
   output logic [2:0] channel_output_pin_out,
   output logic irq_out
);
   initial
   begin
      if (WIDTH != 10)
      begin
         $error("tpwm_unit: register layout serves 10-bit channels only");
      end
   end

   logic [7:0] ctrl1_q;
   logic [7:0] ctrl23_q;
   logic [WIDTH-1:0] period_setpoint_q [3];
   logic [WIDTH-1:0] duty_setpoint_q [3];
   logic [WIDTH-1:0] channel_counter [3];
   logic [2:0] match;
   logic [2:0] pin;
   logic [2:0] period_match_flag_q;
   logic [2:0] interrupt_mask_reg_q;
   logic [2:0] run;
   logic [2:0] out_en;
   tpwm_ps_t ps [3];
   logic sleep_stop_q;
   logic sleep_seen_q;
   logic tick;
   logic tick_q;
   logic [15:0] rdata_d;

   // ***********************************************
   // Instruction-cycle tick and sleep gating
   // ***********************************************
   // Tick every 1 or 2 clocks: one clock models two oscillator periods
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         tick_q <= 1'b0;
      else
         tick_q <= ~tick_q;
   end
   assign tick = (clks_four_in == `TPWM_CLKS_FOUR) ? tick_q : 1'b1;

   // Sleep decision frozen on entry: an ADC busy at entry keeps counters running
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !sleep_in)
         sleep_stop_q <= 1'b0;
      else if (!sleep_seen_q && !adc_busy_in)
         sleep_stop_q <= 1'b1;
   end

   // Sleep level of the last cycle; only the entry cycle may decide to stop,
   // so a conversion that ends during sleep leaves the counters running
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         sleep_seen_q <= 1'b0;
      else
         sleep_seen_q <= sleep_in;
   end

   // Enables and prescale fields per channel
   assign run[0] = ctrl1_q[`TPWM_C1_EN_BIT] && !sleep_stop_q;
   assign run[1] = ctrl23_q[`TPWM_C2_EN_BIT] && !sleep_stop_q;
   assign run[2] = ctrl23_q[`TPWM_C3_EN_BIT] && !sleep_stop_q;
   assign out_en = ctrl1_q[`TPWM_C1_OUTEN_LSB +: 3];
   assign ps[0] = ctrl1_q[2:0];
   assign ps[1] = ctrl23_q[`TPWM_C2_PS_LSB +: 3];
   assign ps[2] = ctrl23_q[`TPWM_C3_PS_LSB +: 3];

   // ***********************************************
   // Register writes
   // ***********************************************
   // Control registers; reset clears prescale selections
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ctrl1_q <= `TPWM_CTRL_RST;
         ctrl23_q <= `TPWM_CTRL_RST;
         interrupt_mask_reg_q <= 3'h0;
      end
      else if (wr_in)
      begin
         if (addr_in == `TPWM_OFF_CTRL1)
            ctrl1_q <= wdata_in[7:0] & 8'hEF; // Bit 4 is fixed at zero
         else if (addr_in == `TPWM_OFF_CTRL23)
            ctrl23_q <= wdata_in[7:0];
         else if (addr_in == `TPWM_OFF_MASK)
            interrupt_mask_reg_q <= wdata_in[2:0];
      end
   end

   // Setpoints: duty may be written any time, it only waits in this register
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < 3; i++)
         begin
            period_setpoint_q[i] <= '0;
            duty_setpoint_q[i] <= '0;
         end
      end
      else if (wr_in)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (addr_in == 8'(`TPWM_OFF_PERIOD1 + i))
               period_setpoint_q[i] <= wdata_in[WIDTH-1:0];
            else if (addr_in == 8'(`TPWM_OFF_DUTY1 + i))
               duty_setpoint_q[i] <= wdata_in[WIDTH-1:0];
         end
      end
   end

   // ***********************************************
   // Channels
   // ***********************************************
   for (genvar g = 0; g < 3; g++)
   begin : gen_ch
      tpwm_channel #(
         .WIDTH(WIDTH)
      ) u_ch (
         .clk_in(clk_in),
         .sys_rst_in(sys_rst_in),
         .tick_in(tick),
         .run_in(run[g]),
         .out_en_in(out_en[g]),
         .prescale_in(ps[g]),
         .period_in(period_setpoint_q[g]),
         .duty_in(duty_setpoint_q[g]),
         .count_out(channel_counter[g]),
         .pin_out(pin[g]),
         .match_out(match[g])
      );
   end

   // Output pins already come from flops inside the channels; one more stage keeps them aligned
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         channel_output_pin_out <= 3'h0;
      else
         channel_output_pin_out <= pin;
   end

   // ***********************************************
   // Interrupt status
   // ***********************************************
   // Sticky match flags, write one to clear; a new match wins over the clear
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         period_match_flag_q <= 3'h0;
      else if (wr_in && addr_in == `TPWM_OFF_STATUS)
         period_match_flag_q <= (period_match_flag_q & ~wdata_in[2:0]) | match;
      else
         period_match_flag_q <= period_match_flag_q | match;
   end

   // Level interrupt while any unmasked flag is set
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(period_match_flag_q & interrupt_mask_reg_q);
   end

   // ***********************************************
   // Register reads
   // ***********************************************
   // Counters readable only; unmapped addresses read zero
   always_comb
   begin
      rdata_d = 16'h0000;
      if (addr_in == `TPWM_OFF_CTRL1)
         rdata_d = {8'h00, ctrl1_q};
      else if (addr_in == `TPWM_OFF_CTRL23)
         rdata_d = {8'h00, ctrl23_q};
      else if (addr_in == `TPWM_OFF_STATUS)
         rdata_d = {13'h0000, period_match_flag_q};
      else if (addr_in == `TPWM_OFF_MASK)
         rdata_d = {13'h0000, interrupt_mask_reg_q};
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (addr_in == 8'(`TPWM_OFF_PERIOD1 + i))
               rdata_d = 16'(period_setpoint_q[i]);
            else if (addr_in == 8'(`TPWM_OFF_DUTY1 + i))
               rdata_d = 16'(duty_setpoint_q[i]);
            else if (addr_in == 8'(`TPWM_OFF_COUNT1 + i))
               rdata_d = 16'(channel_counter[i]);
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !rd_in)
         rdata_out <= 16'h0000;
      else
         rdata_out <= rdata_d;
   end
endmodule

/* File: tpwm_unit_checker.sv */
// Port-level assertions for the three-channel PWM timer unit.
// Assumes one clock clk_in and the synchronous reset sys_rst_in.
module tpwm_unit_checker
   import tpwm_pkg::*;
#(
   parameter int WIDTH = 10
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic sleep_in,
   input wire logic adc_busy_in,
   input wire logic clks_four_in,
   input wire logic [15:0] rdata_out,
   input wire logic [2:0] channel_output_pin_out,
   input wire logic irq_out
);
   // ********************
   // Assertions
   // ********************
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst_in |=>
      channel_output_pin_out == 3'h0 && irq_out == 1'b0 && rdata_out == 16'h0000)
      else $error("outputs not quiet after reset");
   AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
      else $error("read data outside read slot");
   AST_CTRL1_LAYOUT: assert property (rd_in && addr_in == 8'h05 |=>
      rdata_out[15:8] == 8'h00 && rdata_out[4] == 1'b0)
      else $error("control one unused bits not zero");
   AST_UNMAPPED: assert property (rd_in && addr_in > 8'h21 |=> rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   AST_COUNT_NONZERO: assert property (rd_in && addr_in inside {8'h18, 8'h19, 8'h1A}
      |=> rdata_out[9:0] != 10'h000)
      else $error("counter read as zero");
   AST_WORD_WIDTH: assert property (rd_in && addr_in[7:4] == 4'h1
      |=> rdata_out[15:10] == 6'h00)
      else $error("setpoint or counter wider than ten bits");
   AST_OUTEN_OFF: assert property (wr_in && addr_in == 8'h05 && wdata_in[7:5] == 3'h0
      |-> ##3 channel_output_pin_out == 3'h0)
      else $error("pin active with output disabled");
   AST_MASK_OFF: assert property (wr_in && addr_in == 8'h21 && wdata_in[2:0] == 3'h0
      |-> ##2 (!irq_out) [*3])
      else $error("interrupt high with mask clear");

   // Main scenarios reached
   cover property ($rose(channel_output_pin_out[0]));
   cover property ($rose(irq_out));
   cover property (sleep_in && adc_busy_in);
endmodule

bind tpwm_unit tpwm_unit_checker #(.WIDTH(WIDTH)) u_tpwm_unit_checker (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .sleep_in(sleep_in), .adc_busy_in(adc_busy_in),
   .clks_four_in(clks_four_in), .rdata_out(rdata_out),
   .channel_output_pin_out(channel_output_pin_out), .irq_out(irq_out));
